// ---- design/asrc_pkg.sv ----
// Purpose: Shared constants and types for the serial readout chain
// Assumes: 200 MHz system clock, six channels in three pairs
// Function
// - Select falling drives first result MSB
// - Sixteen-bit words MSB first, zero padded
// - First bit before first fall, shift on rises
// - Chain inputs feed lines A, B, C
// - Convert rising starts, read after busy low
// - Two lines chained: 96 clocks, 48 each
// - Two lines: A gets 1,2,5; B 3,4,6
// - Far end shifts zeros after own data
// - Split 16-clock frames keep chain running
// - Three lines chained: 64 clocks, 32 each
// - Start low before busy ends powers pair down
// - Start high wakes pair; host waits power-up
// - Other pairs convert while one sleeps
// - Standby low sleeps device, high wakes
// - Output buffers work during standby
// - Busy rises on start, falls 3 us later
// - Line enables gate outputs A, B, C
`default_nettype none

package asrc_pkg;
   // Timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int CONV_TIME_NS  = 3000;
   localparam int CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;  // Longest time, rounds down
   localparam int CONV_CNT_W    = 10;

   // Geometry
   localparam int WORD_BITS = 16;
   localparam int NUM_CH    = 6;
   localparam int NUM_PAIR  = 3;
   localparam int NUM_LINE  = 3;
   localparam int LINE_BITS = 96;

   // Register map (byte addresses)
   localparam int               ADR_W      = 4;
   localparam logic [ADR_W-1:0] ADR_CTRL   = 4'h0;
   localparam logic [ADR_W-1:0] ADR_STATUS = 4'h4;

   // Control fields
   localparam int         CTRL_SERIAL = 0;
   localparam int         CTRL_CHAIN  = 1;
   localparam int         CTRL_STANDBY_INPUT   = 2;
   localparam int         CTRL_LINE   = 4;
   localparam logic [7:0] CTRL_RESET  = 8'h75;

   // Status fields
   localparam int ST_BUSY  = 0;
   localparam int ST_PD    = 1;
   localparam int ST_FRESH = 4;
   localparam int ST_FRAME = 5;

   typedef enum logic [0:0] {
      CV_IDLE = 1'b0,
      CV_RUN  = 1'b1
   } asrc_conv_state_t;
endpackage : asrc_pkg

`default_nettype wire

// ---- design/asrc_conv_if.sv ----
// Purpose: Carries pair start events and conversion status
// Assumes: Both ends on the system clock
// Notes:   Rise and level come from synchronised pins
`default_nettype none

interface asrc_conv_if;
   logic [2:0] start_rise;
   logic [2:0] start_level;
   logic       awake;
   logic       busy;
   logic       done;
   logic [2:0] active;
   logic [2:0] pd;

   modport ctl  (input start_rise, start_level, awake, output busy, done, active, pd);
   modport user (output start_rise, start_level, awake, input busy, done, active, pd);
endinterface : asrc_conv_if

`default_nettype wire

// ---- design/asrc_sync.sv ----
// Purpose: Two-flop synchroniser with edge detection
// Assumes: Inputs are asynchronous pins
// Notes:   Edges are taken from the second and third flops only
`default_nettype none

module asrc_sync
   import asrc_pkg::*;
#(
   parameter int           W         = 8,
   parameter logic [W-1:0] RST_VALUE = '0
)
(
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         rst,
   // Pins and results
   input  wire logic [W-1:0] raw,
   output logic      [W-1:0] level,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
   } asrc_sync_st_t;

   asrc_sync_st_t q, d;

   // Shift chain; first stage feeds only the second
   always_comb
   begin
      d    = q;
      d.s1 = raw;
      d.s2 = q.s1;
      d.s3 = q.s2;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         q <= '{s1: RST_VALUE, s2: RST_VALUE, s3: RST_VALUE};
      else
         q <= d;
   end

   assign level = q.s2;
   assign rise  = q.s2 & ~q.s3;
   assign fall  = ~q.s2 & q.s3;
endmodule : asrc_sync

`default_nettype wire

// ---- design/asrc_conv.sv ----
// Purpose: Conversion timer and per-pair power-down
// Assumes: Start edges already synchronised
// Notes:   Starts arriving during a conversion start nothing, but before its last cycle still wake sleeping pairs
`default_nettype none

module asrc_conv
   import asrc_pkg::*;
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // Pair control
   asrc_conv_if.ctl  cv
);
   typedef struct packed {
      asrc_conv_state_t        st;
      logic [CONV_CNT_W-1:0]   cnt;
      logic                    busy;
      logic                    done;
      logic [NUM_PAIR-1:0]     active;
      logic [NUM_PAIR-1:0]     pd;
   } asrc_conv_st_t;

   asrc_conv_st_t q, d;

   always_comb
   begin
      d      = q;
      d.done = 1'b0;
      // A sleeping pair only wakes on its start edge, it does not convert
      d.pd   = q.pd & ~cv.start_rise;
      case (q.st)
         CV_IDLE:
         begin
            // Awake pairs convert; sleeping ones stay out of it
            if (cv.awake && |(cv.start_rise & ~q.pd))
            begin
               d.st     = CV_RUN;
               d.busy   = 1'b1;
               d.cnt    = '0;
               d.active = cv.start_rise & ~q.pd;
            end
         end
         CV_RUN:
         begin
            d.cnt = q.cnt + 1'b1;
            if (q.cnt == CONV_CNT_W'(CONV_CYCLES - 1))
            begin
               d.st   = CV_IDLE;
               d.busy = 1'b0;
               d.done = 1'b1;
               d.pd   = q.pd | (q.active & ~cv.start_level);
            end
         end
         default:
            d.st = CV_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         q <= '{st: CV_IDLE, default: '0};
      else
         q <= d;
   end

   assign cv.busy   = q.busy;
   assign cv.done   = q.done;
   assign cv.active = q.active;
   assign cv.pd     = q.pd;
endmodule : asrc_conv

`default_nettype wire

// ---- design/asrc_top.sv ----
// Purpose: Serial result readout with daisy chain and power control
// Assumes: Select, serial clock, chain and start pins are asynchronous
// Notes:   Serial clock is oversampled by the system clock
`default_nettype none

module asrc_top
   import asrc_pkg::*;
#(
   parameter int RES_BITS = 16
)
(
   // Clock and reset
   input  wire logic                               clock,
   input  wire logic                               rst,
   // Wishbone slave
   input  wire logic                               wb_cyc_i,
   input  wire logic                               wb_stb_i,
   input  wire logic                               wb_we_i,
   input  wire logic [ADR_W-1:0]                   wb_adr_i,
   input  wire logic [3:0]                         wb_sel_i,
   input  wire logic [31:0]                        wb_dat_i,
   output logic      [31:0]                        wb_dat_o,
   output logic                                    wb_ack_o,
   // Serial port
   input  wire logic                               cs_n,
   input  wire logic                               sclk,
   output logic      [NUM_LINE-1:0]                dout,
   output logic      [NUM_LINE-1:0]                dout_oe,
   input  wire logic [NUM_LINE-1:0]                chain_input,
   // Conversion control
   input  wire logic [NUM_PAIR-1:0]                pair_convert_start,
   output logic                                    busy,
   // Converter cores
   input  wire logic [NUM_CH-1:0][RES_BITS-1:0]    core_result
);
   typedef struct packed {
      logic [7:0]                             ctrl;
      logic                                   ack;
      logic [31:0]                            rdat;
      logic [NUM_CH-1:0][WORD_BITS-1:0]       bank;
      logic                                   fresh;
      logic                                   in_frame;
      logic                                   seen_fall;
      logic [NUM_LINE-1:0]                    chain_bit;
      logic [NUM_LINE-1:0][LINE_BITS-1:0]     shreg;
      logic [NUM_LINE-1:0]                    dout;
      logic [NUM_LINE-1:0]                    oe;
   } asrc_top_st_t;

   asrc_top_st_t q, d;

   // Number of lines in use from the enable field
   function automatic logic [1:0] asrc_lines(input logic [2:0] en);
      if (en[2])
         return 2'd3;
      else if (en[1])
         return 2'd2;
      else
         return 2'd1;
   endfunction

   // Own words of one line, first word highest, right-justified
   function automatic logic [LINE_BITS-1:0] asrc_load(
      input logic [1:0]                       lc,
      input int                               line,
      input logic [NUM_CH-1:0][WORD_BITS-1:0] b
   );
      logic [LINE_BITS-1:0] r;
      r = '0;
      case (lc)
         2'd1:
            if (line == 0)
               r = {b[0], b[1], b[2], b[3], b[4], b[5]};
         2'd2:
            if (line == 0)
               r = {48'h0, b[0], b[1], b[4]};
            else if (line == 1)
               r = {48'h0, b[2], b[3], b[5]};
         default:
            if (line == 0)
               r = {64'h0, b[0], b[1]};
            else if (line == 1)
               r = {64'h0, b[2], b[3]};
            else
               r = {64'h0, b[4], b[5]};
      endcase
      return r;
   endfunction

   // Bit on the pin: top of the line's own data length
   function automatic logic asrc_top_bit(input logic [1:0] lc, input logic [LINE_BITS-1:0] v);
      if (lc == 2'd1)
         return v[95];
      else if (lc == 2'd2)
         return v[47];
      else
         return v[31];
   endfunction

   // Pin synchronisers: bit0 select, bit1 clock, then chain and starts
   logic [7:0] pin_lvl;
   logic [7:0] pin_rise;
   logic [7:0] pin_fall;

   asrc_sync #(
      .W         (8),
      .RST_VALUE (8'h03)
   ) u_sync (
      .clock (clock),
      .rst   (rst),
      .raw   ({pair_convert_start, chain_input, sclk, cs_n}),
      .level (pin_lvl),
      .rise  (pin_rise),
      .fall  (pin_fall)
   );

   // Conversion timing and pair power state
   asrc_conv_if cvi ();

   asrc_conv u_conv (
      .clock (clock),
      .rst   (rst),
      .cv    (cvi.ctl)
   );

   assign cvi.start_rise  = pin_rise[7:5];
   assign cvi.start_level = pin_lvl[7:5];
   assign cvi.awake       = q.ctrl[CTRL_STANDBY_INPUT];

   logic       serial_mode;
   logic       chain_on;
   logic [2:0] line_en;
   logic [1:0] lc;

   // Decoded controls
   assign serial_mode = q.ctrl[CTRL_SERIAL];
   assign chain_on    = q.ctrl[CTRL_CHAIN] & serial_mode;
   assign line_en     = q.ctrl[CTRL_LINE +: 3];
   assign lc          = asrc_lines(line_en);

   always_comb
   begin
      d     = q;
      // Bus: answer one cycle after the request, write on the ack edge
      d.ack = wb_cyc_i & wb_stb_i & ~q.ack;
      if (wb_cyc_i && wb_stb_i && !q.ack)
      begin
         if (wb_adr_i == ADR_CTRL)
            d.rdat = {24'h0, q.ctrl};
         else if (wb_adr_i == ADR_STATUS)
            d.rdat = {26'h0, q.in_frame, q.fresh, cvi.pd, cvi.busy};
         else
            d.rdat = 32'h0;
      end
      if (wb_cyc_i && wb_stb_i && q.ack && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTRL)
         d.ctrl = wb_dat_i[7:0];

      // Select falling opens a frame; new results load only once
      if (pin_fall[0] && serial_mode)
      begin
         d.in_frame  = 1'b1;
         d.seen_fall = 1'b0;
         if (q.fresh)
         begin
            d.fresh = 1'b0;
            for (int l = 0; l < NUM_LINE; l++)
               d.shreg[l] = asrc_load(lc, l, q.bank);
         end
      end
      if (pin_rise[0])
         d.in_frame = 1'b0;

      // Host samples on falls; chain bit is caught there too
      if (q.in_frame && pin_fall[1])
      begin
         d.seen_fall = 1'b1;
         d.chain_bit = pin_lvl[4:2];
      end
      // Shift on rises after the first fall; keeps going across frames
      if (q.in_frame && q.seen_fall && pin_rise[1])
      begin
         for (int l = 0; l < NUM_LINE; l++)
            d.shreg[l] = {q.shreg[l][LINE_BITS-2:0],
                          chain_on & q.chain_bit[l]};
      end

      // Conversion end stores results; set wins over the frame's clear
      if (cvi.done)
      begin
         for (int c = 0; c < NUM_CH; c++)
            if (cvi.active[c/2])
               d.bank[c] = WORD_BITS'(core_result[c]);
         d.fresh = 1'b1;
      end

      // Pins follow standby-independent buffers
      for (int l = 0; l < NUM_LINE; l++)
      begin
         d.dout[l] = asrc_top_bit(lc, d.shreg[l]);
         d.oe[l]   = d.in_frame & line_en[l] & serial_mode;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         q <= '{ctrl: CTRL_RESET, default: '0};
      else
         q <= d;
   end

   // Outputs straight from flops
   assign wb_dat_o = q.rdat;
   assign wb_ack_o = q.ack;
   assign dout     = q.dout;
   assign dout_oe  = q.oe;
   assign busy     = cvi.busy;
endmodule : asrc_top

`default_nettype wire

// ---- test/asrc_props.sv ----
// Purpose: Port assertions for the serial readout chain
// Assumes: Bound to asrc_top, one clock domain
// Notes:   Pins are oversampled, so windows allow a few cycles of lag
`default_nettype none

module asrc_props
   import asrc_pkg::*;
(
   // Clock and reset
   input wire logic                clock,
   input wire logic                rst,
   // Bus
   input wire logic                wb_cyc_i,
   input wire logic                wb_stb_i,
   input wire logic                wb_ack_o,
   // Serial and conversion
   input wire logic                cs_n,
   input wire logic                sclk,
   input wire logic [NUM_LINE-1:0] dout,
   input wire logic [NUM_LINE-1:0] dout_oe,
   input wire logic [NUM_PAIR-1:0] pair_convert_start,
   input wire logic                busy
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [CONV_CNT_W-1:0] busy_cnt_q;

   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   // Length of the busy pulse so far
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         busy_cnt_q <= '0;
      else
         busy_cnt_q <= busy ? busy_cnt_q + 1'b1 : '0;
   end

   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus ack missing");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack too long");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("bus ack without request");
   a_busy_width: assert property ($fell(busy) |-> busy_cnt_q == CONV_CYCLES)
      else $error("busy width wrong");
   a_busy_rearm: assert property ($fell(busy) |=> !busy)
      else $error("busy rearmed at once");
   a_busy_cause: assert property ($rose(busy) |-> $past(pair_convert_start, 2) != '0)
      else $error("busy without start");
   a_oe_closed: assert property (cs_n [*8] |-> dout_oe == '0)
      else $error("line driven outside frame");
   // Data may only move after a clock, select or bus event
   a_dout_quiet: assert property (
      ($stable(sclk) && $stable(cs_n) && $stable(wb_cyc_i)) [*8] |-> $stable(dout))
      else $error("data moved without clock");
endmodule // asrc_props

bind asrc_top asrc_props u_props (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cs_n(cs_n), .sclk(sclk), .dout(dout),
   .dout_oe(dout_oe), .pair_convert_start(pair_convert_start), .busy(busy));

`default_nettype wire

// ---- test/asrc_host.sv ----
// Purpose: Host serial master plus upstream chained converter
// Assumes: Serial clock idles high, period 48 ns
// Notes:   Samples late in the low phase, as the pins lag by a few cycles
`default_nettype none

module asrc_host
   import asrc_pkg::*;
(
   // Serial port
   output logic                           cs_n,
   output logic                           sclk,
   output logic      [NUM_LINE-1:0]       chain_input,
   input  wire logic [NUM_LINE-1:0]       dout,
   input  wire logic [NUM_LINE-1:0]       dout_oe,
   // Upstream results
   input  wire logic [NUM_LINE-1:0][47:0] up
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [NUM_LINE-1:0][95:0] rx;
   logic [NUM_LINE-1:0][47:0] sh;
   logic [NUM_LINE-1:0]       oe_seen;

   // Idle link: clock stands still high
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b1;
      chain_input = 3'h5;
   end

   // One frame of n clocks; upstream output lags its clock by 12 ns
   task automatic frame(input int n);
      // Quarter-step offset keeps every pin move off the system clock's rising edge
      #1.25;
      rx = '0;
      sh = up;
      cs_n = 1'b0;
      for (int l = 0; l < NUM_LINE; l++) chain_input[l] = sh[l][47];
      #24;
      for (int i = 0; i < n; i++)
      begin
         sclk = 1'b0;
         #22;
         if (i == 0) oe_seen = dout_oe;
         for (int l = 0; l < NUM_LINE; l++) rx[l] = {rx[l][94:0], dout[l]};
         #2;
         sclk = 1'b1;
         #12;
         for (int l = 0; l < NUM_LINE; l++) sh[l] = {sh[l][46:0], 1'b0};
         for (int l = 0; l < NUM_LINE; l++) chain_input[l] = sh[l][47];
         #12;
      end
      cs_n = 1'b1;
      chain_input = ~chain_input;
      // Idle gap so a following frame sees select high; with the 1.25 ns opening step it adds ten system clocks
      #48.75;
   endtask
endmodule // asrc_host

`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose: Self-checking bench for the serial readout chain
// Assumes: 12-bit results, so four leading zeros per word
// Notes:   Each table row uses a fresh conversion
`default_nettype none

module tb_top
   import asrc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int RB = 12;
   localparam logic [NUM_CH-1:0][RB-1:0] RS =
      {12'h6a6, 12'h5b5, 12'h4c4, 12'h3d3, 12'h2e2, 12'h1f1};
   localparam logic [NUM_LINE-1:0][47:0] UP =
      {48'h3c5a9f017e42, 48'hd28b16c4a937, 48'h81f35e6d0b2c};

   typedef struct {logic [7:0] c; int n; logic [2:0] oe;} asrc_row_t;

   asrc_row_t   rows [6] = '{'{8'h15, 96, 3'h1}, '{8'h35, 48, 3'h3}, '{8'h75, 32, 3'h7},
                            '{8'h37, 96, 3'h3}, '{8'h77, 64, 3'h7}, '{8'h35, 64, 3'h3}};
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [3:0]  adr = '0;
   logic [31:0] dat = '0;
   logic [31:0] q;
   logic [31:0] dat_o;
   logic        ack;
   logic        busy;
   logic        cs_n;
   logic        sclk;
   logic [2:0]  st = '0;
   logic [2:0]  dout;
   logic [2:0]  oe;
   logic [2:0]  chain;
   logic [95:0] e;
   int          failures = 0;
   int          total_checks = 0;
   int          ticks = 0;

   // 200 MHz clock
   always #2.5 clock = ~clock;

   asrc_top #(.RES_BITS(RB)) DUT (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .cs_n(cs_n), .sclk(sclk), .dout(dout), .dout_oe(oe),
      .chain_input(chain), .pair_convert_start(st), .busy(busy), .core_result(RS));

   asrc_host host (.cs_n(cs_n), .sclk(sclk), .chain_input(chain), .dout(dout),
      .dout_oe(oe), .up(UP));

   task automatic close_out;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [95:0] g, input logic [95:0] x);
      total_checks++;
      if (g !== x)
      begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
   endtask

   // Classic single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clock);
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      @(posedge clock);
      while (ack !== 1'b1 && t < 50)
      begin
         t++;
         @(posedge clock);
      end
      // A missing answer counts as a mismatch
      if (ack !== 1'b1)
      begin
         failures++;
         $display("[ERR] %0t bus ack got %h exp %h", $time, ack, 1'b1);
      end
      q = dat_o;
      {cyc, stb} <= 2'b00;
   endtask

   // Bounded wait for busy, then check it
   task automatic wt(input logic v);
      int t;
      t = 0;
      while (busy !== v && t < 700)
      begin
         t++;
         @(posedge clock);
      end
      chk(busy, v);
   endtask

   task automatic cv(input logic [2:0] p);
      st <= st | p;
      wt(1'b1);
      wt(1'b0);
      st <= st & ~p;
   endtask

   function automatic int ch(input int nl, input int l, input int k);
      return nl == 1 ? k : nl == 3 ? 2 * l + k : l == 0 ? (k < 2 ? k : 4) : (k < 2 ? k + 2 : 5);
   endfunction

   // Hang guard
   always @(posedge clock)
   begin
      ticks++;
      if (ticks == 40000)
      begin
         failures++;
         close_out();
      end
   end

   initial
   begin
      int nl;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      wb(1'b0, ADR_CTRL, '0);
      chk(q, 32'h75);
      wb(1'b0, ADR_STATUS, '0);
      chk(q, '0);
      wb(1'b0, 4'h8, '0);
      chk(q, '0);
      foreach (rows[r])
      begin
         wb(1'b1, ADR_CTRL, {24'h0, rows[r].c});
         cv(3'h7);
         host.frame(rows[r].n);
         chk(host.oe_seen, rows[r].oe);
         nl = $countones(rows[r].oe);
         for (int l = 0; l < nl; l++)
         begin
            e = '0;
            for (int k = 0; k < 6 / nl; k++)
               e = {e[79:0], 4'h0, RS[ch(nl, l, k)]};
            // Past own data: upstream bits when chained, zeros otherwise
            for (int b = 0; b < rows[r].n - 96 / nl; b++)
               e = {e[94:0], UP[l][47-b] & rows[r].c[CTRL_CHAIN]};
            chk(host.rx[l], e);
         end
      end
      wb(1'b1, ADR_CTRL, 32'h17);
      cv(3'h7);
      for (int k = 0; k < 2; k++)
      begin
         host.frame(16);
         chk(host.rx[0], {84'h0, RS[k]});
      end
      wb(1'b1, ADR_CTRL, 32'h75);
      st <= 3'h1;
      wt(1'b1);
      st <= 3'h0;
      wt(1'b0);
      wb(1'b0, ADR_STATUS, '0);
      chk(q & 32'he, 32'h2);
      cv(3'h2);
      @(posedge clock);
      st <= 3'h1;
      repeat (20) @(posedge clock);
      chk(busy, 1'b0);
      wb(1'b0, ADR_STATUS, '0);
      chk(q & 32'he, 32'h0);
      st <= 3'h0;
      repeat (8) @(posedge clock);
      cv(3'h1);
      wb(1'b1, ADR_CTRL, 32'h71);
      st <= 3'h4;
      repeat (20) @(posedge clock);
      chk(busy, 1'b0);
      host.frame(16);
      chk(host.oe_seen, 3'h7);
      st <= 3'h0;
      wb(1'b1, ADR_CTRL, 32'h75);
      repeat (8) @(posedge clock);
      cv(3'h4);
      close_out();
   end
endmodule // tb_top

`default_nettype wire
